// ===== rtc_core.sv
// Calendar clock with alarm, periodic interrupt and read snapshot
`timescale 1ns/100ps
// Overview of operation
// - Eight-bit data bus, driven on reads
// - Eight addressable read/write time counters
// - Counters advance from divided oscillator tick
// - Four crystal choices give one tick rate
// - Multiplexed address captured by latch strobe
// - Hundredths to 99 years, year wraps
// - Hour counter in 12 or 24 format
// - Month lengths and leap day automatic
// - Periodic interrupt at six selectable rates
// - 51-bit alarm memory written by processor
// - Alarm interrupt when time equals alarm
// - Status register shows interrupt source
// - Supply loss blocks bus, time continues
// - Reading hundredths snapshots all counters
// - Snapshot held until next hundredths read
// - Write-only command register at 0x11
// - Command bits: test, irq, run, 24h, crystal
// - Counters at 0x00-0x07, alarm from 0x08
module rtc_core
   import rtc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic ale,
   input wire logic [4:0] addr,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic data_oe,
   input wire logic osc_in,
   input wire logic power_fail,
   output logic irq_o,
   output logic int_source_o
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Returns {carry, next}; out-of-range values also wrap to lo
   function automatic logic [8:0] step(input logic [7:0] v,
      input logic [7:0] lo, input logic [7:0] hi);
      if (v >= hi) begin
         step = {1'b1, lo};
      end else begin
         step = {1'b0, v + 8'h01};
      end
   endfunction

   function automatic logic [7:0] month_days(input logic [7:0] mo,
      input logic [7:0] yr);
      unique case (mo)
         8'h02: month_days = (yr[1:0] == 2'h0) ? 8'h1D : 8'h1C;
         8'h04, 8'h06, 8'h09, 8'h0B: month_days = 8'h1E;
         default: month_days = 8'h1F;
      endcase
   endfunction

   localparam state_t ST_RST = '{cnt: CNT_RST, default: '0};

   state_t q, d;
   logic rd_act, wr_act, rd_go, wr_go, tick, alarm_hit;
   logic c_hs, c_s, c_m, c_h;
   logic [5:0] per;
   logic [7:0][7:0] t;
   logic [8:0] r;
   logic [4:0] hr;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      r = '0;
      hr = '0;
      c_hs = 1'b0;
      c_s = 1'b0;
      c_m = 1'b0;
      c_h = 1'b0;
      alarm_hit = 1'b0;
      // Every bus, oscillator and supply pin goes through two flops before it is used
      d.s1 = '{pwr: power_fail, osc: osc_in, ale: ale, wr: ~wr_n,
         rd: ~rd_n, cs: ~cs_n, addr: addr, data: data_i};
      d.s2 = q.s1;
      rd_act = q.s2.rd & q.s2.cs & ~q.s2.pwr;
      wr_act = q.s2.wr & q.s2.cs & ~q.s2.pwr;
      rd_go = rd_act & ~q.rd_prev;
      // Data is taken at the end of strobe; a supply loss that cuts a
      // strobe short must not commit it
      wr_go = ~wr_act & q.wr_prev & ~q.s2.pwr;
      d.rd_prev = rd_act;
      d.wr_prev = wr_act;
      // Transparent while strobe is high; holding it high gives direct
      // addressing, a pulse captures a multiplexed address
      if (q.s2.ale) begin
         d.addr = q.s2.addr;
      end

      // Fractional divide: exact 100 Hz average from any crystal
      tick = 1'b0;
      d.osc_prev = q.s2.osc;
      if (q.s2.osc & ~q.osc_prev) begin
         if (q.acc + TICK_HZ >= XTAL_HZ[q.cmd.xtal]) begin
            d.acc = q.acc + TICK_HZ - XTAL_HZ[q.cmd.xtal];
            tick = q.cmd.run;
         end else begin
            d.acc = q.acc + TICK_HZ;
         end
         if (q.cmd.test) begin
            tick = q.cmd.run;
         end
      end

      // Counter cascade
      t = q.cnt;
      if (tick) begin
         r = step(t[IX_HSEC], 8'h00, MAX_HSEC);
         {c_hs, t[IX_HSEC]} = r;
         if (c_hs) begin
            r = step(t[IX_SEC], 8'h00, MAX_MS);
            {c_s, t[IX_SEC]} = r;
         end
         if (c_s) begin
            r = step(t[IX_MIN], 8'h00, MAX_MS);
            {c_m, t[IX_MIN]} = r;
         end
         if (c_m) begin
            if (q.cmd.h24) begin
               r = step(t[IX_HOUR], 8'h00, MAX_H24);
               {c_h, t[IX_HOUR]} = r;
            end else begin
               hr = t[IX_HOUR][4:0];
               if (hr >= NOON || hr == 5'h00) begin
                  t[IX_HOUR][4:0] = 5'h01;
               end else begin
                  t[IX_HOUR][4:0] = hr + 5'h01;
                  if (hr == NOON - 5'h01) begin
                     c_h = t[IX_HOUR][PM_BIT];
                     t[IX_HOUR][PM_BIT] = ~t[IX_HOUR][PM_BIT];
                  end
               end
            end
         end
         if (c_h) begin
            r = step(t[IX_DOW], 8'h00, MAX_DOW);
            t[IX_DOW] = r[7:0];
            r = step(t[IX_DATE], 8'h01,
               month_days(t[IX_MONTH], t[IX_YEAR]));
            t[IX_DATE] = r[7:0];
            if (r[8]) begin
               r = step(t[IX_MONTH], 8'h01, MAX_MONTH);
               t[IX_MONTH] = r[7:0];
               if (r[8]) begin
                  r = step(t[IX_YEAR], 8'h00, MAX_YEAR);
                  t[IX_YEAR] = r[7:0];
               end
            end
         end
         alarm_hit = 1'b1;
         for (int i = 0; i < 8; i++) begin
            if ((t[i] & ALARM_MASK[i]) != (q.alarm[i] & ALARM_MASK[i]))
            begin
               alarm_hit = 1'b0;
            end
         end
      end
      d.cnt = t;
      per = {c_h, c_m, c_s, c_hs,
         tick && (t[IX_HSEC] % 8'h0A == 8'h00), tick};

      // Status: a read clears it, a new event in that cycle still sets
      if (rd_go && q.addr == ADR_INT) begin
         d.stat = '0;
      end
      d.stat = d.stat | {per, alarm_hit};

      // Snapshot and read data; reads are fixed at strobe start
      if (rd_go) begin
         if (q.addr == ADR_HSEC) begin
            d.snap = q.cnt;
            d.rdata = q.cnt[IX_HSEC];
         end else if (q.addr <= ADR_LAST_CNT) begin
            d.rdata = q.snap[q.addr[2:0]];
         end else if (q.addr <= ADR_LAST_ALARM) begin
            d.rdata = q.alarm[q.addr[2:0]] & ALARM_MASK[q.addr[2:0]];
         end else if (q.addr == ADR_INT) begin
            d.rdata = {|(q.stat & q.imask), q.stat};
         end else begin
            d.rdata = '0; // Command register is write-only
         end
      end

      // Writes come last so they override a same-cycle increment
      if (wr_go) begin
         if (q.addr <= ADR_LAST_CNT) begin
            d.cnt[q.addr[2:0]] = q.s2.data;
         end else if (q.addr <= ADR_LAST_ALARM) begin
            d.alarm[q.addr[2:0]] = q.s2.data;
         end else if (q.addr == ADR_INT) begin
            d.imask = q.s2.data[6:0];
         end else if (q.addr == ADR_CMD) begin
            d.cmd = cmd_t'(q.s2.data[5:0]);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Open-drain style interrupt: only asserted while enabled
   assign irq_o = q.cmd.int_en & |(q.stat & q.imask);
   assign int_source_o = q.cmd.int_en & q.stat[0] & q.imask[0];
   assign data_o = q.rdata;
   assign data_oe = rd_act;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   pwr_block_a: assert property (
      q.s2.pwr |-> !data_oe && !wr_go)
      else $error("bus active during supply loss");
   stop_hold_a: assert property (
      !q.cmd.run && !wr_go |=> q.cnt == $past(q.cnt))
      else $error("counters moved while stopped");
   hsec_wrap_a: assert property (
      tick && !wr_go && q.cnt[IX_HSEC] == MAX_HSEC
      |=> q.cnt[IX_HSEC] == 8'h00 && q.stat[3])
      else $error("hundredths wrap lost");
   snap_take_a: assert property (
      rd_go && q.addr == ADR_HSEC |=> q.snap == $past(q.cnt))
      else $error("snapshot not taken");
   snap_hold_a: assert property (
      !(rd_go && q.addr == ADR_HSEC) |=> $stable(q.snap))
      else $error("snapshot changed without read");
   alarm_flag_a: assert property (
      alarm_hit |=> q.stat[0] ##1 (q.stat[0] || $past(rd_go)))
      else $error("alarm event not recorded");
   per_irq_a: assert property (
      tick && q.cmd.int_en && q.imask[1] && !wr_go |=> irq_o)
      else $error("periodic interrupt missing");
   cmd_write_a: assert property (
      wr_go && q.addr == ADR_CMD
      |=> q.cmd == cmd_t'($past(q.s2.data[5:0])))
      else $error("command write lost");
   hour24_wrap_a: assert property (
      c_m && !wr_go && q.cmd.h24 && q.cnt[IX_HOUR] == MAX_H24
      |=> q.cnt[IX_HOUR] == 8'h00)
      else $error("24-hour wrap wrong");
endmodule

// ===== rtc_pkg.sv
// Constants and types shared by the calendar clock
package rtc_pkg;
   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   localparam logic [4:0] ADR_HSEC = 5'h00;
   localparam logic [4:0] ADR_LAST_CNT = 5'h07;
   localparam logic [4:0] ADR_ALARM = 5'h08;
   localparam logic [4:0] ADR_LAST_ALARM = 5'h0F;
   localparam logic [4:0] ADR_INT = 5'h10;
   localparam logic [4:0] ADR_CMD = 5'h11;
   // ----------------------------------------------------------------
   // Counter indices, limits and field masks
   // ----------------------------------------------------------------
   localparam int IX_HSEC = 0;
   localparam int IX_HOUR = 1;
   localparam int IX_MIN = 2;
   localparam int IX_SEC = 3;
   localparam int IX_MONTH = 4;
   localparam int IX_DATE = 5;
   localparam int IX_YEAR = 6;
   localparam int IX_DOW = 7;
   localparam logic [7:0] MAX_HSEC = 8'h63;
   localparam logic [7:0] MAX_MS = 8'h3B;
   localparam logic [7:0] MAX_H24 = 8'h17;
   localparam logic [7:0] MAX_MONTH = 8'h0C;
   localparam logic [7:0] MAX_YEAR = 8'h63;
   localparam logic [7:0] MAX_DOW = 8'h06;
   localparam logic [4:0] NOON = 5'h0C;
   localparam int PM_BIT = 7;
   // Alarm field widths add up to 51 stored bits
   localparam logic [7:0][7:0] ALARM_MASK =
      {8'h0F, 8'h7F, 8'h3F, 8'h1F, 8'h7F, 8'h7F, 8'hFF, 8'h7F};
   localparam logic [7:0][7:0] CNT_RST =
      {8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h0C, 8'h00};
   // ----------------------------------------------------------------
   // Tick generation
   // ----------------------------------------------------------------
   localparam logic [22:0] TICK_HZ = 23'h000064;
   localparam logic [3:0][22:0] XTAL_HZ =
      {23'h400000, 23'h200000, 23'h100000, 23'h008000};
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic test;
      logic int_en;
      logic run;
      logic h24;
      logic [1:0] xtal;
   } cmd_t;
   typedef struct packed {
      logic pwr;
      logic osc;
      logic ale;
      logic wr;
      logic rd;
      logic cs;
      logic [4:0] addr;
      logic [7:0] data;
   } pins_t;
   typedef struct packed {
      pins_t s1;
      pins_t s2;
      logic osc_prev;
      logic rd_prev;
      logic wr_prev;
      logic [4:0] addr;
      logic [22:0] acc;
      logic [7:0][7:0] cnt;
      logic [7:0][7:0] snap;
      logic [7:0][7:0] alarm;
      cmd_t cmd;
      logic [6:0] imask;
      logic [6:0] stat;
      logic [7:0] rdata;
   } state_t;
endpackage

// ===== rtc_cpu_model.sv
// Processor bus model driving the clock's pins
`timescale 1ns/100ps
module rtc_cpu_model (
   input wire logic ref_clk,
   input wire logic [7:0] data_o,
   input wire logic data_oe,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic ale,
   output logic [4:0] addr,
   output logic [7:0] data_i
);
   // ----------------
   // Bus cycles
   // ----------------
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      ale = 1'b1;
      addr = 5'h00;
      data_i = 8'h00;
   end
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Released data lines show the inverse of the last value, never a held copy
   task automatic bus_wr(input logic [4:0] a, input logic [7:0] d,
      input bit mux);
      @(posedge ref_clk);
      addr <= a;
      cs_n <= 1'b0;
      data_i <= d;
      idle(4);
      if (mux) begin
         ale <= 1'b0;
         idle(3);
         addr <= ~a;
         idle(1);
      end
      wr_n <= 1'b0;
      idle(6);
      wr_n <= 1'b1;
      idle(5);
      cs_n <= 1'b1;
      ale <= 1'b1;
      data_i <= ~d;
      idle(4);
   endtask
   task automatic bus_rd(input logic [4:0] a, output logic [7:0] d,
      output logic oe);
      @(posedge ref_clk);
      addr <= a;
      cs_n <= 1'b0;
      idle(3);
      rd_n <= 1'b0;
      idle(7);
      d = data_o;
      oe = data_oe;
      rd_n <= 1'b1;
      cs_n <= 1'b1;
      idle(5);
   endtask
endmodule

// ===== bus_rtc_calendar_alarm_test.sv
// Self-checking bench for the calendar clock
`timescale 1ns/100ps
module bus_rtc_calendar_alarm_test;
   import rtc_pkg::*;
   logic ref_clk, srst, osc_in, power_fail, cs_n, rd_n, wr_n, ale;
   logic data_oe, irq_o, int_source_o, oe;
   logic [4:0] addr;
   logic [7:0] data_i, data_o, d, old;
   logic [31:0] lfsr_q = 32'hA98691C0;
   int err_count = 0;
   int cmp_count = 0;
   int tm[8];
   int rows[3][8] = '{'{99, 23, 59, 59, 2, 28, 4, 3},
      '{99, 23, 59, 59, 12, 31, 99, 6}, '{99, 139, 59, 59, 3, 5, 1, 6}};
   logic [7:0] cmds[3] = '{8'h2C, 8'h2C, 8'h28};
   rtc_core u_rtc_core (.ref_clk(ref_clk), .srst(srst), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .addr(addr), .data_i(data_i),
      .data_o(data_o), .data_oe(data_oe), .osc_in(osc_in),
      .power_fail(power_fail), .irq_o(irq_o),
      .int_source_o(int_source_o));
   rtc_cpu_model u_rtc_cpu_model (.ref_clk(ref_clk), .data_o(data_o),
      .data_oe(data_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .ale(ale), .addr(addr), .data_i(data_i));
   // ----------------
   // Reference model and helpers
   // ----------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function void adv(input bit h24);
      int h, dim;
      h = tm[1] & 31;
      dim = (tm[4] == 2) ? ((tm[6] % 4 == 0) ? 29 : 28) :
         (tm[4] inside {4, 6, 9, 11}) ? 30 : 31;
      tm[0]++;
      if (tm[0] < 100) return;
      tm[0] = 0;
      tm[3]++;
      if (tm[3] < 60) return;
      tm[3] = 0;
      tm[2]++;
      if (tm[2] < 60) return;
      tm[2] = 0;
      if (h24) begin
         tm[1] = (tm[1] + 1) % 24;
         if (tm[1] != 0) return;
      end else if (h == 11) begin
         tm[1] = (tm[1] ^ 128) + 1;
         if (tm[1] >= 128) return;
      end else begin
         tm[1] = (h == 12) ? (tm[1] & 128) + 1 : tm[1] + 1;
         return;
      end
      tm[7] = (tm[7] + 1) % 7;
      tm[5]++;
      if (tm[5] <= dim) return;
      tm[5] = 1;
      tm[4]++;
      if (tm[4] <= 12) return;
      tm[4] = 1;
      tm[6] = (tm[6] + 1) % 100;
   endfunction
   task automatic check(input string name, input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic pulse();
      @(posedge ref_clk);
      osc_in <= 1'b1;
      repeat (3) @(posedge ref_clk);
      osc_in <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic read_all();
      for (int i = 0; i < 8; i++) begin
         u_rtc_cpu_model.bus_rd(5'(i), d, oe);
         check("counter", d, 8'(tm[i]));
         check("drive", {7'h00, oe}, 8'h01);
      end
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ----------------
   // Stimulus
   // ----------------
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (50000) @(posedge ref_clk);
      err_count++;
      print_verdict();
   end
   initial begin
      srst = 1'b1;
      osc_in = 1'b0;
      power_fail = 1'b0;
      repeat (12) @(posedge ref_clk);
      srst <= 1'b0;
      foreach (tm[i]) tm[i] = CNT_RST[i];
      read_all();
      u_rtc_cpu_model.bus_rd(5'h15, d, oe);
      check("unmapped", d, 8'h00);
      // 330 edges at 32768 Hz is just over one hundredth
      u_rtc_cpu_model.bus_wr(ADR_CMD, 8'h08, 0);
      repeat (330) pulse();
      u_rtc_cpu_model.bus_wr(ADR_CMD, 8'h00, 0);
      tm[0] = 1;
      read_all();
      for (int r = 0; r < 3; r++) begin
         foreach (tm[i]) tm[i] = rows[r][i];
         u_rtc_cpu_model.bus_wr(ADR_CMD, cmds[r], 0);
         foreach (tm[i]) u_rtc_cpu_model.bus_wr(5'(i), 8'(tm[i]), r == 1);
         adv(cmds[r][2]);
         if (r == 0) begin
            foreach (tm[i])
               u_rtc_cpu_model.bus_wr(ADR_ALARM + 5'(i), 8'(tm[i]), 0);
            u_rtc_cpu_model.bus_wr(ADR_INT, 8'h03, 0);
            u_rtc_cpu_model.bus_wr(ADR_CMD, cmds[r] | 8'h10, 0);
         end
         pulse();
         u_rtc_cpu_model.idle(4);
         if (r == 0) begin
            check("irq", {7'h00, irq_o}, 8'h01);
            check("source", {7'h00, int_source_o}, 8'h01);
            u_rtc_cpu_model.bus_rd(ADR_INT, d, oe);
            check("status", d & 8'h81, 8'h81);
            u_rtc_cpu_model.bus_wr(ADR_CMD, cmds[r], 0);
         end
         read_all();
      end
      u_rtc_cpu_model.bus_wr(ADR_HSEC, 8'h63, 0);
      tm[0] = 99;
      old = 8'(tm[3]);
      adv(0);
      pulse();
      u_rtc_cpu_model.bus_rd(5'(IX_SEC), d, oe);
      check("held", d, old);
      read_all();
      power_fail <= 1'b1;
      u_rtc_cpu_model.idle(4);
      u_rtc_cpu_model.bus_wr(5'(IX_DOW), 8'h05, 0);
      u_rtc_cpu_model.bus_rd(ADR_HSEC, d, oe);
      check("blocked", {7'h00, oe}, 8'h00);
      pulse();
      adv(0);
      power_fail <= 1'b0;
      u_rtc_cpu_model.idle(4);
      lfsr_q = lfsr_next(lfsr_q);
      tm[2] = lfsr_q % 60;
      u_rtc_cpu_model.bus_wr(5'(IX_MIN), 8'(tm[2]), 0);
      lfsr_q = lfsr_next(lfsr_q);
      tm[6] = lfsr_q % 100;
      u_rtc_cpu_model.bus_wr(5'(IX_YEAR), 8'(tm[6]), 1);
      read_all();
      print_verdict();
   end
endmodule
